// ---- logic/dprad_pkg.sv ----
// Package: constants and carriers for the dual-port RAM access decode block
package dprad_pkg;
    // Shared RAM geometry: 2K bytes, reserved half is 1K
    localparam int RAM_AW       = 11;
    localparam int RSV_AW       = 10;
    localparam int SYS_AW       = 20;
    localparam int LOC_AW       = 16;
    localparam int WIN_AW       = SYS_AW - RAM_AW;
    // Local map: sockets from zero; RAM clear of the full 16K socket span
    localparam logic [15:0] LOC_RAM_BASE = 16'h8000;
    localparam logic [15:0] LOC_ROM_BASE = 16'h0000;
    localparam logic [10:0] FLAG_ADDR    = 11'h000;
    // Reset values
    localparam logic        FLAG_RST     = 1'b0;
    localparam logic [7:0]  DATA_RST     = 8'h00;

    // Operating configuration
    typedef enum logic [1:0] {
        DPRAD_STANDALONE = 2'h0,
        DPRAD_MASTER     = 2'h1,
        DPRAD_SLAVE      = 2'h2
    } dprad_mode_t;

    // Nonvolatile part sizes
    typedef enum logic [1:0] {
        DPRAD_NV_1K = 2'h0,
        DPRAD_NV_2K = 2'h1,
        DPRAD_NV_4K = 2'h2,
        DPRAD_NV_8K = 2'h3
    } dprad_nv_t;

    // Arbiter states
    typedef enum logic [2:0] {
        DPRAD_IDLE = 3'b001,
        DPRAD_LOC  = 3'b010,
        DPRAD_SYS  = 3'b100
    } dprad_state_t;

    // Request carrier: one memory or I/O cycle
    typedef struct packed {
        logic        req;
        logic        wr;
        logic        io;
        logic [19:0] addr;
        logic [7:0]  wdata;
    } dprad_req_t;

    // Static configuration
    typedef struct packed {
        dprad_mode_t mode;
        logic        reserve;
        logic [8:0]  base;
        dprad_nv_t   nv_type;
    } dprad_cfg_t;
endpackage

// ---- logic/dprad_ctrl.sv ----
// Dual-port shared RAM controller with system window and socket decode
//
// Overview of operation
// R1: Both local and system ports reach RAM
// R2: On-board cycles local, off-board to system
// R3: Reserve switch hides 1K from system
// R4: Base setting places window in 1M
// R5: Local RAM use never takes system bus
// R6: One of three operating modes at once
// R7: Master mode means no other master
// R8: Two same-type sockets, size follows type
// R9: Nonvolatile reads finish without wait states
// R10: System write to word 0 flags local
// R11: Window sits on own-size boundary
// R12: Collision grants one, other waits
module dprad_ctrl
#(
    parameter int RAM_BYTES = 2048
)
(
    input  wire logic                  mclk_in,
    input  wire logic                  rst_in,
    input  wire dprad_pkg::dprad_cfg_t cfg_in,
    input  wire dprad_pkg::dprad_req_t loc_in,
    input  wire dprad_pkg::dprad_req_t sys_in,
    output logic                       loc_ack_out,
    output logic                       loc_wait_out,
    output logic [7:0]                 loc_rdata_out,
    output logic                       loc_rom_sel_out,
    output logic [1:0]                 rom_sock_out,
    output logic                       loc_onboard_out,
    output logic                       loc_sysbus_out,
    output logic                       sys_sel_out,
    output logic                       sys_ack_out,
    output logic                       sys_wait_out,
    output logic [7:0]                 sys_rdata_out,
    output logic                       flag_irq_out
);
    // Structure is sized for exactly 2K of shared storage
    if (RAM_BYTES != (1 << dprad_pkg::RAM_AW))
        $error("dprad_ctrl: RAM_BYTES must be 2048");

    logic [7:0]   mem_q [RAM_BYTES];
    logic         loc_ram;
    logic         loc_nv;
    logic         sys_hit;
    logic [10:0]  loc_ra;
    logic [10:0]  sys_ra;
    logic         nv_size_hit;
    logic [15:0]  nv_off;
    dprad_pkg::dprad_state_t st_q, st_d;
    logic         flag_q, flag_d;
    logic [7:0]   lrd_q, lrd_d, srd_q, srd_d;
    logic         last_loc_q, last_loc_d;
    logic         grant_loc, grant_sys;
    logic         sys_ok;

    // Local decode; RAM cycles and socket reads stay on the internal bus
    always_comb
    begin
        loc_ra  = loc_in.addr[10:0];
        nv_off  = loc_in.addr[15:0] - dprad_pkg::LOC_ROM_BASE;
        unique case (cfg_in.nv_type)                          // R8
            dprad_pkg::DPRAD_NV_1K: nv_size_hit = (nv_off[15:11] == 5'h0);
            dprad_pkg::DPRAD_NV_2K: nv_size_hit = (nv_off[15:12] == 4'h0);
            dprad_pkg::DPRAD_NV_4K: nv_size_hit = (nv_off[15:13] == 3'h0);
            dprad_pkg::DPRAD_NV_8K: nv_size_hit = (nv_off[15:14] == 2'h0);
        endcase
        loc_ram = loc_in.req && !loc_in.io
                  && (loc_in.addr[15:11] == dprad_pkg::LOC_RAM_BASE[15:11]);
        loc_nv  = loc_in.req && !loc_in.io && !loc_in.wr && nv_size_hit;
    end

    // Socket select: upper half of the decoded size picks socket two
    always_comb
    begin
        unique case (cfg_in.nv_type)                          // R8
            dprad_pkg::DPRAD_NV_1K: rom_sock_out = nv_off[10] ? 2'b10 : 2'b01;
            dprad_pkg::DPRAD_NV_2K: rom_sock_out = nv_off[11] ? 2'b10 : 2'b01;
            dprad_pkg::DPRAD_NV_4K: rom_sock_out = nv_off[12] ? 2'b10 : 2'b01;
            dprad_pkg::DPRAD_NV_8K: rom_sock_out = nv_off[13] ? 2'b10 : 2'b01;
        endcase
        if (!loc_nv)
            rom_sock_out = 2'b00;
    end

    // Sockets answer at once, with no wait state
    assign loc_rom_sel_out = loc_nv;                          // R9
    assign loc_onboard_out = loc_ram || loc_nv;               // R2
    // Off-board cycles go out; never allowed to outrun the internal bus
    assign loc_sysbus_out  = loc_in.req && !loc_onboard_out;  // R2 R5

    // System window: only slave mode answers, aligned 2K base
    always_comb
    begin
        sys_ra  = sys_in.addr[10:0];
        sys_ok  = (cfg_in.mode == dprad_pkg::DPRAD_SLAVE);    // R6
        sys_hit = sys_in.req && !sys_in.io && sys_ok
                  && (sys_in.addr[19:11] == cfg_in.base)      // R4 R11
                  && !(cfg_in.reserve && !sys_ra[dprad_pkg::RSV_AW]); // R3
    end
    assign sys_sel_out = sys_hit;

    // Arbiter: alternate priority on a tie; loser waits
    always_comb
    begin
        grant_loc  = 1'b0;
        grant_sys  = 1'b0;
        last_loc_d = last_loc_q;
        if (loc_ram && sys_hit)                               // R12
        begin
            grant_loc = !last_loc_q;
            grant_sys = last_loc_q;
        end
        else
        begin
            grant_loc = loc_ram;
            grant_sys = sys_hit;
        end
        if (grant_loc)
            last_loc_d = 1'b1;
        else if (grant_sys)
            last_loc_d = 1'b0;
        unique case (st_q)
            dprad_pkg::DPRAD_IDLE: st_d = dprad_pkg::DPRAD_IDLE;
            dprad_pkg::DPRAD_LOC:  st_d = dprad_pkg::DPRAD_IDLE;
            dprad_pkg::DPRAD_SYS:  st_d = dprad_pkg::DPRAD_IDLE;
            default:               st_d = dprad_pkg::DPRAD_IDLE;
        endcase
        if (grant_loc)
            st_d = dprad_pkg::DPRAD_LOC;
        else if (grant_sys)
            st_d = dprad_pkg::DPRAD_SYS;
    end
    assign loc_wait_out = loc_ram && !grant_loc;              // R12
    assign sys_wait_out = sys_hit && !grant_sys;              // R12

    // Read data and flag; system write sets, local read clears, set wins
    always_comb
    begin
        lrd_d  = lrd_q;
        srd_d  = srd_q;
        flag_d = flag_q;
        if (grant_loc && !loc_in.wr)                          // R1
            lrd_d = mem_q[loc_ra];
        if (grant_sys && !sys_in.wr)                          // R1
            srd_d = mem_q[sys_ra];
        if (loc_nv)
            lrd_d = dprad_pkg::DATA_RST;
        if (grant_loc && !loc_in.wr && loc_ra == dprad_pkg::FLAG_ADDR)
            flag_d = 1'b0;                                    // R10
        if (grant_sys && sys_in.wr && sys_ra == dprad_pkg::FLAG_ADDR)
            flag_d = 1'b1;                                    // R10
    end

    // Registers
    always_ff @(posedge mclk_in)
    begin
        if (rst_in)
        begin
            st_q       <= dprad_pkg::DPRAD_IDLE;
            flag_q     <= dprad_pkg::FLAG_RST;
            lrd_q      <= dprad_pkg::DATA_RST;
            srd_q      <= dprad_pkg::DATA_RST;
            last_loc_q <= 1'b0;
        end
        else
        begin
            st_q       <= st_d;
            flag_q     <= flag_d;
            lrd_q      <= lrd_d;
            srd_q      <= srd_d;
            last_loc_q <= last_loc_d;
        end
    end

    // Storage: at most one port writes per cycle
    always_ff @(posedge mclk_in)
    begin
        if (grant_loc && loc_in.wr)                           // R1 R5
            mem_q[loc_ra] <= loc_in.wdata;
        else if (grant_sys && sys_in.wr)                      // R1
            mem_q[sys_ra] <= sys_in.wdata;
    end

    assign loc_ack_out   = (st_q == dprad_pkg::DPRAD_LOC);
    assign sys_ack_out   = (st_q == dprad_pkg::DPRAD_SYS);
    assign loc_rdata_out = lrd_q;
    assign sys_rdata_out = srd_q;
    assign flag_irq_out  = flag_q;

    // Checks
    one_grant_a: assert property (@(posedge mclk_in) disable iff (rst_in) // R12
        !(grant_loc && grant_sys)) else $error("both ports granted");
    loser_waits_a: assert property (@(posedge mclk_in) disable iff (rst_in) // R12
        (loc_ram && sys_hit) |-> (loc_wait_out != sys_wait_out))
        else $error("collision not resolved");
    flag_set_a: assert property (@(posedge mclk_in) disable iff (rst_in) // R10
        (grant_sys && sys_in.wr && sys_ra == 11'h000) |=> flag_irq_out)
        else $error("flag not raised");
    flag_clr_a: assert property (@(posedge mclk_in) disable iff (rst_in) // R10
        (grant_loc && !loc_in.wr && loc_ra == 11'h000 && !(grant_sys))
        |=> !flag_irq_out) else $error("flag not cleared");
    reserve_hide_a: assert property (@(posedge mclk_in) disable iff (rst_in) // R3
        (cfg_in.reserve && !sys_in.addr[10]) |-> !sys_sel_out)
        else $error("reserved segment visible");
    slave_only_a: assert property (@(posedge mclk_in) disable iff (rst_in) // R6
        (cfg_in.mode != dprad_pkg::DPRAD_SLAVE) |-> !sys_sel_out)
        else $error("window open outside slave mode");
    base_match_a: assert property (@(posedge mclk_in) disable iff (rst_in) // R4
        sys_sel_out |-> (sys_in.addr[19:11] == cfg_in.base))
        else $error("window off base");
    nv_nowait_a: assert property (@(posedge mclk_in) disable iff (rst_in) // R9
        loc_rom_sel_out |-> (!loc_wait_out && !loc_sysbus_out))
        else $error("socket read delayed");
    ram_local_a: assert property (@(posedge mclk_in) disable iff (rst_in) // R5
        loc_ram |-> !loc_sysbus_out) else $error("local RAM on system bus");
    ack_follow_a: assert property (@(posedge mclk_in) disable iff (rst_in) // R1
        grant_loc |=> loc_ack_out) else $error("local grant not acked");
endmodule // dprad_ctrl

// ---- tb/dprad_sysm.sv ----
// System bus master model facing the shared RAM window
module dprad_sysm
(
    input  wire logic             mclk_in,
    input  wire logic             ack_in,
    input  wire logic             sel_in,
    input  wire logic [7:0]       rdata_in,
    output dprad_pkg::dprad_req_t bus_out
);
    timeunit 1ns;
    timeprecision 1ns;
    // Sole master on the bus, so nothing else ever drives it
    initial bus_out = '0;
    // One byte cycle, held until ack, dropped inside the ack cycle
    task automatic cyc(input logic wr, input logic [19:0] a, input logic [7:0] d,
                       output logic [7:0] r, output logic ok, output logic s);
        int n;
        @(negedge mclk_in);
        bus_out = '{req: 1'b1, wr: wr, io: 1'b0, addr: a, wdata: d};
        #1 s = sel_in;
        ok = 1'b0;
        for (n = 0; n < 20 && !ok; n++)
        begin
            @(negedge mclk_in);
            ok = (ack_in === 1'b1);
        end
        r = rdata_in;
        // Released lines change, so stale values cannot pass
        bus_out = '{req: 1'b0, wr: ~wr, io: 1'b0, addr: ~a, wdata: ~d};
    endtask
endmodule // dprad_sysm

// ---- tb/testbench.sv ----
// Self-checking bench for the shared RAM access and decode block
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [8:0] BASE = 9'h0a5;
    logic                  mclk_in = 1'b0;
    logic                  rst_in  = 1'b1;
    dprad_pkg::dprad_cfg_t cfg_in;
    dprad_pkg::dprad_req_t loc_in, sys_in;
    logic                  loc_ack_out, loc_wait_out, loc_rom_sel_out, loc_onboard_out;
    logic                  loc_sysbus_out, sys_sel_out, sys_ack_out, sys_wait_out, flag_irq_out;
    logic [7:0]            loc_rdata_out, sys_rdata_out, r, r2;
    logic [1:0]            rom_sock_out;
    logic                  ok, ok2, s, s2;
    int                    mismatches = 0;
    int                    cmp_count  = 0;

    always #25 mclk_in = ~mclk_in;

    dprad_ctrl i_dut (.mclk_in(mclk_in), .rst_in(rst_in), .cfg_in(cfg_in), .loc_in(loc_in),
        .sys_in(sys_in), .loc_ack_out(loc_ack_out), .loc_wait_out(loc_wait_out),
        .loc_rdata_out(loc_rdata_out), .loc_rom_sel_out(loc_rom_sel_out),
        .rom_sock_out(rom_sock_out), .loc_onboard_out(loc_onboard_out),
        .loc_sysbus_out(loc_sysbus_out), .sys_sel_out(sys_sel_out), .sys_ack_out(sys_ack_out),
        .sys_wait_out(sys_wait_out), .sys_rdata_out(sys_rdata_out), .flag_irq_out(flag_irq_out));
    dprad_sysm i_sysm (.mclk_in(mclk_in), .ack_in(sys_ack_out), .sel_in(sys_sel_out),
        .rdata_in(sys_rdata_out), .bus_out(sys_in));

    task automatic chk(input string nm, input logic [19:0] seen, input logic [19:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("BAD %s exp %h seen %h", nm, exp, seen);
        end
    endtask

    // Local byte cycle, held until ack with a bounded wait
    task automatic loc_cyc(input logic wr, input logic [15:0] a, input logic [7:0] d);
        int n;
        @(negedge mclk_in);
        loc_in = '{req: 1'b1, wr: wr, io: 1'b0, addr: {4'h0, a}, wdata: d};
        ok = 1'b0;
        for (n = 0; n < 20 && !ok; n++)
        begin
            @(negedge mclk_in);
            ok = (loc_ack_out === 1'b1);
        end
        r = loc_rdata_out;
        loc_in = '{req: 1'b0, wr: ~wr, io: 1'b0, addr: {4'h0, ~a}, wdata: ~d};
    endtask

    // Decode probe: comb outputs looked at in the request cycle itself
    task automatic probe(input logic io, input logic [15:0] a);
        @(negedge mclk_in);
        loc_in = '{req: 1'b1, wr: 1'b0, io: io, addr: {4'h0, a}, wdata: 8'h00};
        #1;
    endtask

    task automatic t_ram;
        loc_cyc(1'b1, 16'h8023, 8'h5a);
        loc_cyc(1'b0, 16'h8023, 8'h00);
        chk("loc rd", {ok, r}, {1'b1, 8'h5a});
        i_sysm.cyc(1'b0, {BASE, 11'h023}, 8'h00, r, ok, s);
        chk("sys rd", {ok, r}, {1'b1, 8'h5a});
        i_sysm.cyc(1'b1, {BASE, 11'h7ff}, 8'ha5, r, ok, s);
        loc_cyc(1'b0, 16'h87ff, 8'h00);
        chk("win top", r, 8'ha5);
        $display("done ram");
    endtask

    task automatic t_flag;
        chk("flag idle", flag_irq_out, 1'b0);
        i_sysm.cyc(1'b1, {BASE, 11'h000}, 8'h3c, r, ok, s);
        repeat (2) @(negedge mclk_in);
        chk("flag set", flag_irq_out, 1'b1);
        loc_cyc(1'b0, 16'h8000, 8'h00);
        chk("flag data", r, 8'h3c);
        repeat (2) @(negedge mclk_in);
        chk("flag clr", flag_irq_out, 1'b0);
        $display("done flag");
    endtask

    // Window only in slave mode; reserved half and other bases never answer
    task automatic t_win;
        for (int m = 0; m < 3; m++)
        begin
            cfg_in.mode = dprad_pkg::dprad_mode_t'(m);
            i_sysm.cyc(1'b0, {BASE, 11'h400}, 8'h00, r, ok, s);
            chk("mode sel", {s, ok}, (m == 2) ? 2'b11 : 2'b00);
        end
        cfg_in.reserve = 1'b1;
        i_sysm.cyc(1'b0, {BASE, 11'h3ff}, 8'h00, r, ok, s);
        chk("rsv low", {s, ok}, 2'b00);
        i_sysm.cyc(1'b0, {BASE, 11'h400}, 8'h00, r, ok, s);
        chk("rsv high", {s, ok}, 2'b11);
        i_sysm.cyc(1'b0, {BASE + 9'h001, 11'h400}, 8'h00, r, ok, s);
        chk("other base", {s, ok}, 2'b00);
        $display("done window");
    endtask

    task automatic t_dec;
        logic [15:0] sz;
        for (int i = 0; i < 4; i++)
        begin
            cfg_in.nv_type = dprad_pkg::dprad_nv_t'(i);
            sz = 16'h0400 << i;
            probe(1'b0, 16'h0000);
            chk("sock one", {loc_rom_sel_out, rom_sock_out}, 3'b101);
            probe(1'b0, sz);
            chk("sock two", {loc_rom_sel_out, rom_sock_out}, 3'b110);
            probe(1'b0, sz << 1);
            chk("no sock", {rom_sock_out, loc_sysbus_out}, 3'b001);
        end
        probe(1'b1, 16'h8000);
        chk("io off", {loc_onboard_out, loc_sysbus_out}, 2'b01);
        probe(1'b0, 16'h8000);
        chk("ram on", {loc_onboard_out, loc_sysbus_out}, 2'b10);
        @(negedge mclk_in);
        loc_in.req = 1'b0;
        $display("done decode");
    endtask

    task automatic t_col;
        fork
            loc_cyc(1'b0, 16'h87ff, 8'h00);
            i_sysm.cyc(1'b0, {BASE, 11'h7ff}, 8'h00, r2, ok2, s2);
            // Last grant before this tie was local, so the system side wins it
            begin
                @(negedge mclk_in);
                #1 chk("tie wait", {loc_wait_out, sys_wait_out}, 2'b10);
            end
        join
        chk("both done", {ok, ok2, r, r2}, {2'b11, 16'ha5a5});
        $display("done collision");
    endtask

    task automatic results;
        $display("checks %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // Whole run needs well under a thousand cycles
    initial
    begin
        #200000;
        mismatches++;
        results();
    end

    initial
    begin
        cfg_in = '{mode: dprad_pkg::DPRAD_SLAVE, reserve: 1'b0, base: BASE,
                   nv_type: dprad_pkg::DPRAD_NV_2K};
        loc_in = '0;
        repeat (20) @(negedge mclk_in);
        rst_in = 1'b0;
        t_ram();
        t_flag();
        t_col();
        t_dec();
        t_win();
        results();
    end
endmodule // testbench
